// >>> bench/datapath_model.sv
// Address datapath model: register file with base write-back
`timescale 1ns/1ps
`default_nettype none
module datapath_model (
  input wire logic core_clk,
  input wire logic load,
  input wire idx_decode_pkg::reg_file_s init,
  input wire idx_decode_pkg::decode_out_s result_ff,
  input wire logic result_valid_ff,
  output idx_decode_pkg::reg_file_s regs
);
  initial regs = '0;
  // Modified base lands only after the result, as a real datapath would
  always @(posedge core_clk) begin
    if (load) begin
      regs <= init;
    end else if (result_valid_ff && result_ff.wb_en) begin
      case (result_ff.base)
        idx_decode_pkg::base_x: regs.x <= result_ff.wb_value;
        idx_decode_pkg::base_y: regs.y <= result_ff.wb_value;
        idx_decode_pkg::base_sp: regs.sp <= result_ff.wb_value;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> bench/idx_decode_asserts.sv
// Port-level checker for the indexed postbyte decoder
`timescale 1ns/1ps
`default_nettype none
module idx_decode_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic indexed_op,
  input wire logic byte_taken_ff,
  input wire idx_decode_pkg::decode_out_s result_ff,
  input wire logic result_valid_ff,
  input wire logic bus_clock_output_ff,
  input wire logic bus_clk_en_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Opcode then postbyte; the decode cycle must refuse any byte
  sequence s_op_post;
    byte_valid && indexed_op ##1 byte_valid;
  endsequence
  sequence s_take_then_refuse;
    byte_taken_ff ##1 !byte_taken_ff;
  endsequence
  a_decode_gap: assert property (s_op_post |=> s_take_then_refuse)
    else $error("byte taken in decode cycle");
  a_valid_pulse: assert property (result_valid_ff |=> !result_valid_ff [*2])
    else $error("result valid too long");
  a_result_holds: assert property (!result_valid_ff && $past(reset_n)
    |-> $stable(result_ff)) else $error("result changed without valid");
  a_wb_modes: assert property (result_valid_ff |-> result_ff.wb_en ==
    (result_ff.mode inside {idx_decode_pkg::mode_pre_mod, idx_decode_pkg::mode_post_mod}))
    else $error("write-back flag wrong");
  a_pre_addr: assert property (result_valid_ff &&
    result_ff.mode == idx_decode_pkg::mode_pre_mod |-> result_ff.eff_addr == result_ff.wb_value)
    else $error("pre address not updated");
  a_post_step: assert property (result_valid_ff &&
    result_ff.mode == idx_decode_pkg::mode_post_mod |-> result_ff.eff_addr != result_ff.wb_value)
    else $error("zero step");
  a_indirect_flag: assert property (result_valid_ff |-> result_ff.indirect ==
    (result_ff.mode inside {idx_decode_pkg::mode_ind16, idx_decode_pkg::mode_ind_d}))
    else $error("indirect flag wrong");
  a_pc_no_wb: assert property (result_valid_ff &&
    result_ff.base == idx_decode_pkg::base_pc |-> !result_ff.wb_en) else $error("pc modified");
  // Output register lags the divider by one edge, so toggling starts two edges after release
  a_bus_toggle: assert property ($past(reset_n) && $past(reset_n, 2) |->
    bus_clock_output_ff != $past(bus_clock_output_ff)) else $error("bus clock not halved");
  a_clk_en_pulse: assert property (bus_clk_en_ff |=> !bus_clk_en_ff ##1 bus_clk_en_ff)
    else $error("bus enable spacing");
endmodule
bind indexed_postbyte_decoder idx_decode_asserts u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .byte_valid(byte_valid), .indexed_op(indexed_op), .byte_taken_ff(byte_taken_ff),
  .result_ff(result_ff), .result_valid_ff(result_valid_ff),
  .bus_clock_output_ff(bus_clock_output_ff), .bus_clk_en_ff(bus_clk_en_ff));
`default_nettype wire

// >>> bench/indexed_postbyte_decoder_test.sv
// Self-checking bench for the indexed postbyte decoder
`timescale 1ns/1ps
`default_nettype none
module indexed_postbyte_decoder_test;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic byte_valid = 1'b0;
  logic [7:0] byte_in = 8'h00;
  logic [7:0] acc_a = 8'h00;
  logic [7:0] acc_b = 8'h00;
  logic indexed_op = 1'b0;
  logic load = 1'b1;
  logic byte_taken_ff;
  logic result_valid_ff;
  logic bus_clock_output_ff;
  logic bus_clk_en_ff;
  idx_decode_pkg::reg_file_s init;
  idx_decode_pkg::reg_file_s regs;
  idx_decode_pkg::decode_out_s result_ff;
  idx_decode_pkg::decode_out_s exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 22;
  always #20 core_clk = ~core_clk;
  indexed_postbyte_decoder dut (.core_clk(core_clk), .reset_n(reset_n), .byte_valid(byte_valid),
    .byte_in(byte_in), .regs(regs), .acc_a(acc_a), .acc_b(acc_b), .indexed_op(indexed_op),
    .byte_taken_ff(byte_taken_ff), .result_ff(result_ff), .result_valid_ff(result_valid_ff),
    .bus_clock_output_ff(bus_clock_output_ff), .bus_clk_en_ff(bus_clk_en_ff));
  datapath_model u_dp (.core_clk(core_clk), .load(load), .init(init), .result_ff(result_ff),
    .result_valid_ff(result_valid_ff), .regs(regs));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic op);
    @(posedge core_clk);
    byte_valid <= 1'b1;
    byte_in <= b;
    indexed_op <= op;
  endtask
  task automatic results();
    $display("Mismatches %0d, comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Expected decode from postbyte, extension word and current registers
  function automatic idx_decode_pkg::decode_out_s want_of(input logic [7:0] pb,
    input logic [15:0] ext, input logic [7:0] op, input logic pg);
    idx_decode_pkg::decode_out_s e;
    logic [15:0] base;
    logic [15:0] off;
    e = '0;
    e.opcode = op;
    e.page2 = pg;
    e.base = idx_decode_pkg::base_reg_e'(pb[7:5] == 3'h7 ? pb[4:3] : pb[7:6]);
    base = regs[79 - 16 * e.base -: 16];
    if (!pb[5]) begin
      off = {{11{pb[4]}}, pb[4:0]};
    end else if (pb[7:5] != 3'h7) begin
      e.mode = pb[4] ? idx_decode_pkg::mode_post_mod : idx_decode_pkg::mode_pre_mod;
      off = pb[3] ? {12'hfff, pb[3:0]} : {12'h000, pb[3:0]} + 16'h0001;
      e.wb_en = 1'b1;
    end else if (!pb[2]) begin
      e.mode = idx_decode_pkg::idx_mode_e'(pb[1] ? {3'h1, pb[0]} : 4'h1);
      off = pb[1] ? ext : {{8{pb[0]}}, ext[7:0]};
    end else begin
      e.mode = idx_decode_pkg::idx_mode_e'(4'h6 + pb[1:0]);
      off = pb[1] ? regs.d : {8'h00, pb[0] ? acc_b : acc_a};
    end
    e.offset = off;
    e.indirect = pb[7:5] == 3'h7 && pb[1:0] == 2'h3;
    e.wb_value = base + off;
    e.eff_addr = pb[7:4] ==? 4'b??11 && pb[7:5] != 3'h7 ? base : base + off;
    return e;
  endfunction
  // Oldest expectation against each result as it appears
  always @(posedge core_clk) begin
    idx_decode_pkg::decode_out_s m;
    logic [15:0] wmask;
    if (result_valid_ff === 1'b1) begin
      m = exp_q.pop_front();
      wmask = {16{m.wb_en}};
      check(32'({result_ff.base, result_ff.mode}), 32'({m.base, m.mode}));
      check(32'({result_ff.indirect, result_ff.wb_en}), 32'({m.indirect, m.wb_en}));
      check(32'(result_ff.offset), 32'(m.offset));
      check(32'({result_ff.page2, result_ff.opcode}), 32'({m.page2, m.opcode}));
      check(32'(result_ff.eff_addr), 32'(m.eff_addr));
      check(32'(result_ff.wb_value & wmask), 32'(m.wb_value & wmask));
    end
  end
  // Every postbyte once, random page, opcode, extension and accumulators
  initial begin
    logic [15:0] ext;
    logic [7:0] op;
    logic pg;
    logic bclk;
    logic bclk_en;
    init = 80'({$random(seed), $random(seed), $random(seed)});
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    load <= 1'b0;
    for (int i = 0; i < 256; i++) begin
      pg = 1'($random(seed));
      op = {1'b1, 7'($random(seed))};
      ext = 16'($random(seed));
      @(posedge core_clk);
      acc_a <= 8'($random(seed));
      acc_b <= 8'($random(seed));
      if (pg) put(8'h18, 1'b0);
      put(op, 1'b1);
      exp_q.push_back(want_of(8'(i), ext, op, pg));
      put(8'(i), 1'b0);
      put(8'($random(seed)), 1'b0); // Refused byte in the decode cycle
      if (i[7:5] == 3'h7 && !i[2] && i[1]) put(ext[15:8], 1'b0);
      if (i[7:5] == 3'h7 && !i[2]) put(ext[7:0], 1'b0);
      @(posedge core_clk);
      byte_valid <= 1'b0;
      byte_in <= ~byte_in; // Released queue shows no stale byte
      for (int w = 0; w < 20 && exp_q.size() > 0; w++) @(posedge core_clk);
      @(posedge core_clk);
    end
    check(32'(exp_q.size()), 32'h0);
    // Bus clock and its enable must both flip at every core edge
    repeat (4) begin
      bclk = bus_clock_output_ff;
      bclk_en = bus_clk_en_ff;
      @(posedge core_clk);
      check(32'(bus_clock_output_ff), 32'(!bclk));
      check(32'(bus_clk_en_ff), 32'(!bclk_en));
    end
    results();
  end
  // Whole run needs about 2100 cycles; nearly three times that means a hang
  initial begin
    repeat (6000) @(posedge core_clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire

// >>> design/idx_decode_defs.svh
// Constants for the indexed postbyte decoder
`ifndef IDX_DECODE_DEFS_SVH
`define IDX_DECODE_DEFS_SVH
`define PAGE2_PREFIX 8'h18
`define BASE_HI 7
`define BASE_LO 6
`define LONG_BASE_HI 4
`define LONG_BASE_LO 3
`define LONG_FORM_TOP 3'h7
`define AUTO_BIT 5
`define ACC_BIT 2
`define BUS_DIV_COUNT 1'h1
`endif

// >>> design/idx_decode_pkg.sv
// Types shared by the indexed postbyte decoder
package idx_decode_pkg;
  typedef enum logic [1:0] {
    base_x = 2'b00,
    base_y = 2'b01,
    base_sp = 2'b10,
    base_pc = 2'b11
  } base_reg_e;

  typedef enum logic [3:0] {
    mode_const5 = 4'h0,
    mode_const9 = 4'h1,
    mode_const16 = 4'h2,
    mode_ind16 = 4'h3,
    mode_pre_mod = 4'h4,
    mode_post_mod = 4'h5,
    mode_acc_a = 4'h6,
    mode_acc_b = 4'h7,
    mode_acc_d = 4'h8,
    mode_ind_d = 4'h9,
    mode_invalid = 4'hf
  } idx_mode_e;

  typedef enum logic [2:0] {
    st_opcode = 3'b000,
    st_opcode2 = 3'b001,
    st_postbyte = 3'b010,
    st_ext_hi = 3'b011,
    st_ext_lo = 3'b100,
    st_done = 3'b101
  } fetch_state_e;

  // Register values fed in from the datapath
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] d;
  } reg_file_s;

  // Result handed to the address datapath
  typedef struct packed {
    base_reg_e base;
    idx_mode_e mode;
    logic indirect;
    logic [15:0] offset;
    logic [15:0] eff_addr;
    logic wb_en;
    logic [15:0] wb_value;
    logic page2;
    logic [7:0] opcode;
  } decode_out_s;
endpackage

// >>> design/indexed_postbyte_decoder.sv
// Indexed postbyte decoder with opcode page tracking and bus clock divider
// Contract
// [RULE1] Postbyte follows opcode, then zero-two extension bytes
// [RULE2] Base field selects X, Y, SP, PC
// [RULE3] Bit5 clear: signed five-bit offset
// [RULE4] 111rr0zs: z selects 9-bit or 16-bit
// [RULE5] 111rr011 is 16-bit offset indirect
// [RULE6] rr1pnnnn auto modify, pre or post
// [RULE7] Step field encodes +1..+8, -8..-1
// [RULE8] Auto modify invalid with program counter
// [RULE9] 111rr1aa accumulator offset A, B, D
// [RULE10] 111rr111 is D offset indirect
// [RULE11] Byte opcodes; prefix 18 selects page two
// [RULE12] Extension bytes supply offsets to instruction
// [RULE13] Bus clock is half input clock
// [RULE14] Address is base plus offset
// [RULE15] Indirect forms flag pointer fetch
// [RULE16] 9-bit uses one byte, 16-bit two
// [RULE17] Pre uses updated value, post original
`timescale 1ns/1ps
`default_nettype none
`include "idx_decode_defs.svh"

module indexed_postbyte_decoder (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire idx_decode_pkg::reg_file_s regs,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic indexed_op,
  output logic byte_taken_ff,
  output idx_decode_pkg::decode_out_s result_ff,
  output logic result_valid_ff,
  output logic bus_clock_output_ff,
  output logic bus_clk_en_ff
);

  // Fetch state and captured bytes
  idx_decode_pkg::fetch_state_e state_ff;
  idx_decode_pkg::fetch_state_e nxt_state;
  logic [7:0] indexing_postbyte_ff;
  logic [7:0] ext_hi_ff;
  logic page2_ff;
  logic [7:0] opcode_ff;
  logic div_ff;

  // Postbyte fields
  logic [1:0] base_register_field;
  logic [1:0] accumulator_offset_field;
  logic long_form;
  logic [1:0] ext_count;
  idx_decode_pkg::idx_mode_e mode;
  logic [15:0] base_val;
  logic [15:0] step;
  logic [15:0] offset;
  logic [15:0] sum;
  logic [15:0] eff_addr;
  logic indirect;
  // Last operand byte in hand this cycle
  logic publish;

  // Long forms carry the base field lower down, under the 111 marker
  assign base_register_field = long_form ? indexing_postbyte_ff[`LONG_BASE_HI:`LONG_BASE_LO]
                                         : indexing_postbyte_ff[`BASE_HI:`BASE_LO]; // see [RULE2]
  assign accumulator_offset_field = indexing_postbyte_ff[1:0];
  assign long_form = (indexing_postbyte_ff[7:5] == `LONG_FORM_TOP);

  // Mode classification of the stored postbyte
  always_comb begin
    mode = idx_decode_pkg::mode_invalid;
    ext_count = 2'h0;
    indirect = 1'b0;
    if (!indexing_postbyte_ff[`AUTO_BIT]) begin
      mode = idx_decode_pkg::mode_const5; // see [RULE3]
    end else if (long_form) begin
      if (!indexing_postbyte_ff[`ACC_BIT]) begin
        case (indexing_postbyte_ff[1:0])
          2'b00, 2'b01: begin
            mode = idx_decode_pkg::mode_const9; // see [RULE4]
            ext_count = 2'h1; // see [RULE16]
          end
          2'b10: begin
            mode = idx_decode_pkg::mode_const16; // see [RULE4]
            ext_count = 2'h2; // see [RULE16]
          end
          default: begin
            mode = idx_decode_pkg::mode_ind16; // see [RULE5]
            ext_count = 2'h2;
            indirect = 1'b1; // see [RULE15]
          end
        endcase
      end else begin
        case (accumulator_offset_field) // see [RULE9]
          2'b00: begin
            mode = idx_decode_pkg::mode_acc_a;
          end
          2'b01: begin
            mode = idx_decode_pkg::mode_acc_b;
          end
          2'b10: begin
            mode = idx_decode_pkg::mode_acc_d;
          end
          default: begin
            mode = idx_decode_pkg::mode_ind_d; // see [RULE10]
            indirect = 1'b1; // see [RULE15]
          end
        endcase
      end
    end else if (base_register_field != idx_decode_pkg::base_pc) begin // see [RULE8]
      // Guard kept although rr 11 with bit 5 set always lands in the long forms
      mode = indexing_postbyte_ff[4] ? idx_decode_pkg::mode_post_mod
                                     : idx_decode_pkg::mode_pre_mod; // see [RULE6]
    end
  end

  // Base register select
  always_comb begin
    case (base_register_field) // see [RULE2]
      2'b00: begin
        base_val = regs.x;
      end
      2'b01: begin
        base_val = regs.y;
      end
      2'b10: begin
        base_val = regs.sp;
      end
      default: begin
        base_val = regs.pc;
      end
    endcase
  end

  // Step: 0000..0111 is +1..+8, 1000..1111 is -8..-1; no zero step
  always_comb begin
    if (indexing_postbyte_ff[3]) begin
      step = {{12{1'b1}}, indexing_postbyte_ff[3:0]}; // see [RULE7]
    end else begin
      // Positive codes are biased by one so a zero step never occurs
      step = {12'h000, indexing_postbyte_ff[3:0]} + 16'h0001; // see [RULE7]
    end
  end

  // Offset per mode; extension low byte comes straight from the queue
  always_comb begin
    case (mode)
      idx_decode_pkg::mode_const5:
        offset = {{11{indexing_postbyte_ff[4]}}, indexing_postbyte_ff[4:0]};
      idx_decode_pkg::mode_const9:
        offset = {{8{indexing_postbyte_ff[0]}}, byte_in}; // see [RULE12]
      idx_decode_pkg::mode_const16, idx_decode_pkg::mode_ind16:
        offset = {ext_hi_ff, byte_in}; // see [RULE12]
      idx_decode_pkg::mode_pre_mod, idx_decode_pkg::mode_post_mod:
        offset = step;
      idx_decode_pkg::mode_acc_a:
        offset = {8'h00, acc_a}; // Accumulators count as unsigned
      idx_decode_pkg::mode_acc_b:
        offset = {8'h00, acc_b};
      idx_decode_pkg::mode_acc_d, idx_decode_pkg::mode_ind_d:
        offset = regs.d;
      default:
        offset = 16'h0000;
    endcase
  end

  assign sum = base_val + offset; // see [RULE14]
  // Post form addresses with the original value, pre with the updated
  assign eff_addr = (mode == idx_decode_pkg::mode_post_mod) ? base_val : sum; // see [RULE17]

  // Result goes out once the decode cycle or the last extension byte is seen
  assign publish = (state_ff == idx_decode_pkg::st_done && ext_count == 2'h0) ||
                   (state_ff == idx_decode_pkg::st_ext_lo && byte_valid); // see [RULE1]

  // Fetch sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      idx_decode_pkg::st_opcode, idx_decode_pkg::st_opcode2: begin
        if (byte_valid) begin
          if (state_ff == idx_decode_pkg::st_opcode && byte_in == `PAGE2_PREFIX) begin
            nxt_state = idx_decode_pkg::st_opcode2; // see [RULE11]
          end else if (indexed_op) begin
            nxt_state = idx_decode_pkg::st_postbyte; // see [RULE1]
          end else begin
            nxt_state = idx_decode_pkg::st_opcode;
          end
        end
      end
      idx_decode_pkg::st_postbyte: begin
        if (byte_valid) begin
          nxt_state = idx_decode_pkg::st_done;
        end
      end
      idx_decode_pkg::st_done: begin
        // Postbyte now stored; decide how many extension bytes follow
        if (ext_count == 2'h2) begin
          nxt_state = idx_decode_pkg::st_ext_hi; // see [RULE1]
        end else if (ext_count == 2'h1) begin
          nxt_state = idx_decode_pkg::st_ext_lo;
        end else begin
          nxt_state = idx_decode_pkg::st_opcode;
        end
      end
      idx_decode_pkg::st_ext_hi: begin
        if (byte_valid) begin
          nxt_state = idx_decode_pkg::st_ext_lo;
        end
      end
      idx_decode_pkg::st_ext_lo: begin
        if (byte_valid) begin
          nxt_state = idx_decode_pkg::st_opcode;
        end
      end
      default: begin
        nxt_state = idx_decode_pkg::st_opcode; // Unused codes recover at a boundary
      end
    endcase
  end

  // Reset puts the fetch back at an opcode boundary
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff <= idx_decode_pkg::st_opcode;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Byte capture
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      indexing_postbyte_ff <= 8'h00;
      ext_hi_ff <= 8'h00;
      opcode_ff <= 8'h00;
      page2_ff <= 1'b0;
      byte_taken_ff <= 1'b0;
    end else begin
      byte_taken_ff <= byte_valid && (state_ff != idx_decode_pkg::st_done);
      if (byte_valid) begin
        case (state_ff)
          idx_decode_pkg::st_opcode: begin
            page2_ff <= (byte_in == `PAGE2_PREFIX);
            opcode_ff <= byte_in;
          end
          idx_decode_pkg::st_opcode2: begin
            opcode_ff <= byte_in; // Page flag stays set from the prefix
          end
          idx_decode_pkg::st_postbyte: begin
            indexing_postbyte_ff <= byte_in;
          end
          idx_decode_pkg::st_ext_hi: begin
            ext_hi_ff <= byte_in;
          end
          default: ;
        endcase
      end
    end
  end

  // Result publish: when the last byte of the operand is in hand
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      result_ff <= '0;
      result_valid_ff <= 1'b0;
    end else begin
      result_valid_ff <= 1'b0;
      if (publish) begin
        result_valid_ff <= 1'b1;
        result_ff.base <= idx_decode_pkg::base_reg_e'(base_register_field);
        result_ff.mode <= mode;
        result_ff.indirect <= indirect; // see [RULE15]
        result_ff.offset <= offset;
        result_ff.eff_addr <= eff_addr;
        result_ff.wb_en <= (mode == idx_decode_pkg::mode_pre_mod) ||
                           (mode == idx_decode_pkg::mode_post_mod); // see [RULE17]
        result_ff.wb_value <= sum;
        result_ff.page2 <= page2_ff;
        result_ff.opcode <= opcode_ff;
      end
    end
  end

  // Divide by two; bus clock and its enable pulse
  // Both leave flip-flops, so the pin never sees a decode glitch
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_ff <= 1'b0;
      bus_clock_output_ff <= 1'b0;
      bus_clk_en_ff <= 1'b0;
    end else begin
      div_ff <= ~div_ff; // see [RULE13]
      bus_clock_output_ff <= div_ff;
      bus_clk_en_ff <= (div_ff == `BUS_DIV_COUNT);
    end
  end

endmodule

`default_nettype wire
